// ==== rtl/sric_consts.vh ====
// Purpose: constants for the reset and interrupt control block
// Assumes: one 100 MHz clock, crystal edge arrives as a one-cycle enable
// Notes:   register offsets are byte addresses on a 32-bit apb bus
// Overview of operation
// R1 - watchdog disabled combinationally by high test voltage in monitor mode
// R2 - illegal opcode sets its status flag and starts internal reset
// R3 - stop with stop-enable option 0 counts as illegal opcode
// R4 - every internal reset drives the reset pin low
// R5 - only opcode fetches from unmapped addresses cause illegal-address reset
// R6 - low-voltage reset holds pin low 4096 cycles, releases cpu 64 later
// R7 - monitor-entry reset input triggers an internal reset
// R8 - prescale counter is 13 bits, advancing on crystal falling edge
// R9 - prescale counter overflow clocks the watchdog counter
// R10 - stop instruction clears the prescale counter
// R11 - stop recovery waits 32 crystal cycles if short option, else 4096
// R12 - pin reset leaves prescale counter alone; counter free-runs after reset
// R13 - requests are latched, arbitrated, result is a registered vector select
// R14 - a latched interrupt is not displaced until serviced or mask cleared; code instead drops a latched hardware request when the mask is set
// R15 - hardware interrupts are evaluated only at instruction end
// R16 - processing needs mask clear and source enable, else next instruction
// R17 - highest priority pending request is serviced first
// R18 - interrupt entry does not stack the high index register
// R19 - software interrupt is taken even with the mask set
// R20 - software interrupt stacks pc, hardware interrupt stacks pc minus one
// R21 - priority: reset, software interrupt, then flags 1 to 16
// R22 - status flags read pending requests; unused bits zero; writes ignored
// R23 - all reset sources share highest priority, no arbitration; code ranks low-voltage reset first, then internal sources
// R24 - vector select is registered at latching and held through the fetch
`ifndef SRIC_CONSTS_VH
`define SRIC_CONSTS_VH
`define SRIC_CNT_W        13
`define SRIC_CNT_ZERO     13'h0000
`define SRIC_CNT_MAX      13'h1fff
`define SRIC_LONG_CYC     13'h1000
`define SRIC_SHORT_CYC    13'h0020
`define SRIC_TAIL_CYC     13'h0040
`define SRIC_PIN_CYC      13'h0020
`define SRIC_NSRC         16
`define SRIC_VEC_W        5
`define SRIC_VEC_NONE     5'h00
`define SRIC_VEC_SWI      5'h01
`define SRIC_OFS_RSTAT    32'h0000_0000
`define SRIC_OFS_INTSTAT  32'h0000_0004
`define SRIC_OFS_INTEN    32'h0000_0008
`define SRIC_OFS_CONFIG   32'h0000_000c
`define SRIC_OFS_CTRL     32'h0000_0010
`define SRIC_RS_ILLEGAL_OPCODE_FLAG      0
`define SRIC_RS_ILLEGAL_ADDRESS_FLAG      1
`define SRIC_RS_LVR       2
`define SRIC_RS_MOD       3
`define SRIC_RS_PIN       4
`define SRIC_CFG_STOPEN   0
`define SRIC_CFG_SHORT_STOP_RECOVERY_OPTION    1
`define SRIC_CTRL_SVC     0
`endif

// ==== rtl/sric_prio.v ====
// Purpose: fixed-priority encoder for the sixteen maskable sources
// Assumes: bit 0 is flag 1, the highest maskable priority
// Notes:   purely combinational; caller registers the result
`timescale 1ns/1ns
`include "sric_consts.vh"
module sric_prio (
    input  wire [15:0] req,
    output reg  [4:0]  vec,
    output reg         any
);
    integer i;
    // scan from lowest to highest so the highest pending wins
    always @* begin
        vec = `SRIC_VEC_NONE;
        any = 1'b0;
        for (i = `SRIC_NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                vec = i[4:0] + 5'h02; // [R17] [R21]
                any = 1'b1;
            end
        end
    end
endmodule // sric_prio

// ==== rtl/sric_top.v ====
// Purpose: reset sources, prescale counter and interrupt latch/arbitration
// Assumes: xclk_fall is a one-cycle enable at each crystal falling edge
// Notes:   vector 1 is software interrupt, 2..17 are flags 1..16
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns
`include "sric_consts.vh"
module sric_top (
    input  wire        ref_clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // crystal and external conditions
    input  wire        xclk_fall,
    input  wire        monitor_mode,
    input  wire        reset_pin_vtst,
    input  wire        irq_pin_vtst,
    input  wire        reset_pin_in_n,
    input  wire        low_voltage_reset,
    input  wire        monitor_entry_reset,
    // cpu side
    input  wire        illegal_opcode,
    input  wire        stop_exec,
    input  wire        bus_access,
    input  wire        opcode_fetch,
    input  wire        addr_unmapped,
    input  wire        instr_done,
    input  wire        cpu_mask,
    input  wire        swi_exec,
    input  wire        stop_wake,
    input  wire [15:0] int_req,
    input  wire        vec_fetch_done,
    // outputs
    output wire        watchdog_disable,
    output wire        watchdog_tick,
    output reg         reset_pin_out,
    output reg         reset_pin_oe,
    output reg         cpu_reset,
    output reg         stop_active,
    output reg         clocks_enable,
    output reg         int_take,
    output reg  [4:0]  vec_sel,
    output reg         stack_pc_minus1,
    output wire        stack_high_index
);
    // one-hot sequencer states; only run accepts a new reset source, so
    // a burst of sources cannot stretch the driven pin phase
    localparam [3:0] ST_RUN  = 4'b0001;
    localparam [3:0] ST_PIN  = 4'b0010;
    localparam [3:0] ST_TAIL = 4'b0100;
    localparam [3:0] ST_LVR  = 4'b1000;

    reg  [`SRIC_CNT_W-1:0] presc;
    reg  [`SRIC_CNT_W-1:0] seq_cnt;
    reg  [3:0]             state;
    reg  [4:0]             reset_status;
    reg  [15:0]            int_enable;
    reg  [1:0]             config_bits;
    reg                    recovering;
    reg                    latched;
    wire [4:0]             pr_vec;
    wire                   pr_any;
    wire [15:0]            gated_req;
    wire                   stop_illegal;
    wire                   illegal_opcode_flag_ev;
    wire                   illegal_address_flag_ev;
    wire                   int_src;
    wire                   bus_wr;
    wire                   bus_rd;
    wire                   stop_ok;
    wire [`SRIC_CNT_W-1:0] rec_len;

    // address match helper, used by both read and write decode
    function hit;
        input [31:0] a;
        input [31:0] ofs;
        begin
            hit = (a[7:0] == ofs[7:0]);
        end
    endfunction

    // apb: zero wait states, every access answers in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign bus_wr  = psel & penable & pwrite;
    assign bus_rd  = psel & ~pwrite;

    // combinational gate so noise on the level cannot latch a disable
    assign watchdog_disable = monitor_mode &
                              (reset_pin_vtst | irq_pin_vtst); // [R1]

    // stop with the stop-enable option clear is an illegal opcode
    assign stop_illegal = stop_exec & ~config_bits[`SRIC_CFG_STOPEN]; // [R3]
    assign stop_ok      = stop_exec &  config_bits[`SRIC_CFG_STOPEN];
    assign illegal_opcode_flag_ev      = illegal_opcode | stop_illegal; // [R2]
    // data fetches from holes are harmless, only opcode fetches reset
    assign illegal_address_flag_ev = bus_access & opcode_fetch & addr_unmapped; // [R5]
    // all internal sources are equal, no arbitration among them
    assign int_src = illegal_opcode_flag_ev | illegal_address_flag_ev | monitor_entry_reset; // [R7] [R23]

    // overflow of the prescaler clocks the watchdog
    // one tick per 8192 crystal edges while the count runs free
    assign watchdog_tick = xclk_fall & (presc == `SRIC_CNT_MAX); // [R9]

    // interrupt entry never stacks the high index register
    assign stack_high_index = 1'b0; // [R18]

    assign rec_len = config_bits[`SRIC_CFG_SHORT_STOP_RECOVERY_OPTION] ?
                     `SRIC_SHORT_CYC : `SRIC_LONG_CYC; // [R11]

    // 13-bit prescaler on crystal falling edges; pin reset leaves it alone
    // internal resets restart it so reset and stop timing start from zero
    always @(posedge ref_clk) begin
        if (rst) begin
            presc <= `SRIC_CNT_ZERO;
        end else if (stop_ok) begin
            presc <= `SRIC_CNT_ZERO; // [R10]
        end else if (int_src | low_voltage_reset) begin
            presc <= `SRIC_CNT_ZERO;
        end else if (stop_active & ~recovering) begin
            presc <= `SRIC_CNT_ZERO; // held clear until recovery starts
        end else if (xclk_fall) begin
            presc <= presc + 13'h0001; // [R8] [R12]
        end
    end

    // stop entry and recovery timing
    // clocks stay off from the stop edge until the recovery count is done
    always @(posedge ref_clk) begin
        if (rst) begin
            stop_active   <= 1'b0;
            recovering    <= 1'b0;
            clocks_enable <= 1'b1;
        end else if (stop_ok) begin
            stop_active   <= 1'b1;
            recovering    <= 1'b0;
            clocks_enable <= 1'b0;
        end else if (stop_active & ~recovering & stop_wake) begin
            recovering <= 1'b1;
        end else if (recovering & xclk_fall &
                     (presc == rec_len - 13'h0001)) begin
            stop_active   <= 1'b0; // [R11]
            recovering    <= 1'b0;
            clocks_enable <= 1'b1;
        end
    end

    // reset sequencer: pin low phase then held internal reset tail
    // sources seen while a sequence runs set their flags and clear the prescaler; a fresh
    // sequence would lengthen the pulse seen by external peripherals
    always @(posedge ref_clk) begin
        if (rst) begin
            state         <= ST_RUN;
            seq_cnt       <= `SRIC_CNT_ZERO;
            reset_pin_out <= 1'b1;
            reset_pin_oe  <= 1'b0;
            cpu_reset     <= 1'b0;
        end else begin
            case (state)
            ST_RUN: begin
                if (low_voltage_reset) begin
                    state         <= ST_LVR;
                    seq_cnt       <= `SRIC_CNT_ZERO;
                    reset_pin_out <= 1'b0; // [R4] [R6]
                    reset_pin_oe  <= 1'b1;
                    cpu_reset     <= 1'b1;
                end else if (int_src) begin
                    state         <= ST_PIN;
                    seq_cnt       <= `SRIC_CNT_ZERO;
                    reset_pin_out <= 1'b0; // [R4]
                    reset_pin_oe  <= 1'b1;
                    cpu_reset     <= 1'b1;
                end else begin
                    cpu_reset <= ~reset_pin_in_n; // pin reset halts cpu
                end
            end
            ST_LVR: begin
                if (xclk_fall) begin
                    if (seq_cnt == `SRIC_LONG_CYC - 13'h0001) begin
                        state   <= ST_TAIL; // [R6]
                        seq_cnt <= `SRIC_CNT_ZERO;
                        reset_pin_oe  <= 1'b0;
                        reset_pin_out <= 1'b1;
                    end else begin
                        seq_cnt <= seq_cnt + 13'h0001;
                    end
                end
            end
            ST_PIN: begin
                if (xclk_fall) begin
                    if (seq_cnt == `SRIC_PIN_CYC - 13'h0001) begin
                        state   <= ST_TAIL;
                        seq_cnt <= `SRIC_CNT_ZERO;
                        reset_pin_oe  <= 1'b0;
                        reset_pin_out <= 1'b1;
                    end else begin
                        seq_cnt <= seq_cnt + 13'h0001;
                    end
                end
            end
            ST_TAIL: begin
                // lvr tail is 64 cycles; the short path shares it
                if (xclk_fall) begin
                    if (seq_cnt == `SRIC_TAIL_CYC - 13'h0001) begin
                        state     <= ST_RUN; // [R6]
                        cpu_reset <= 1'b0;
                    end else begin
                        seq_cnt <= seq_cnt + 13'h0001;
                    end
                end
            end
            default: begin
                state <= ST_RUN;
            end
            endcase
        end
    end

    // reset status flags: set wins over a software clear
    // a flag raised in the cycle of its clear must not be lost
    always @(posedge ref_clk) begin
        if (rst) begin
            reset_status <= 5'h00;
        end else begin
            if (bus_wr & hit(paddr, `SRIC_OFS_RSTAT)) begin
                reset_status <= reset_status & ~pwdata[4:0];
            end
            if (illegal_opcode_flag_ev) begin
                reset_status[`SRIC_RS_ILLEGAL_OPCODE_FLAG] <= 1'b1; // [R2]
            end
            if (illegal_address_flag_ev) begin
                reset_status[`SRIC_RS_ILLEGAL_ADDRESS_FLAG] <= 1'b1; // [R5]
            end
            if (low_voltage_reset) begin
                reset_status[`SRIC_RS_LVR] <= 1'b1; // [R6]
            end
            if (monitor_entry_reset) begin
                reset_status[`SRIC_RS_MOD] <= 1'b1; // [R7]
            end
            if (~reset_pin_in_n & ~reset_pin_oe) begin
                reset_status[`SRIC_RS_PIN] <= 1'b1;
            end
        end
    end

    // software-writable enables and option bits
    // config wakes with stop enabled and the long, crystal-safe recovery
    always @(posedge ref_clk) begin
        if (rst) begin
            int_enable  <= 16'h0000;
            config_bits <= 2'h1;
        end else if (bus_wr) begin
            if (hit(paddr, `SRIC_OFS_INTEN)) begin
                int_enable <= pwdata[15:0];
            end
            if (hit(paddr, `SRIC_OFS_CONFIG)) begin
                config_bits <= pwdata[1:0];
            end
        end
    end

    // only enabled sources take part in arbitration
    // disabled sources still show in the status register for debugging
    assign gated_req = int_req & int_enable; // [R16]

    sric_prio u_prio (
        .req (gated_req),
        .vec (pr_vec),
        .any (pr_any)
    );

    // latch at instruction end; hold vector until serviced or, for a hardware request, the mask is set
    always @(posedge ref_clk) begin
        if (rst | cpu_reset) begin
            latched         <= 1'b0;
            int_take        <= 1'b0;
            vec_sel         <= `SRIC_VEC_NONE;
            stack_pc_minus1 <= 1'b0;
        end else begin
            int_take <= 1'b0;
            if (latched) begin
                // nothing displaces the latched request; a hardware one
                // is dropped if the mask is set again before its fetch
                if (vec_fetch_done | (cpu_mask & stack_pc_minus1 &
                    (vec_sel != `SRIC_VEC_SWI))) begin
                    latched <= 1'b0; // [R14]
                end
            end else if (instr_done) begin // [R15]
                if (swi_exec) begin
                    latched         <= 1'b1; // [R19]
                    int_take        <= 1'b1;
                    vec_sel         <= `SRIC_VEC_SWI; // [R21]
                    stack_pc_minus1 <= 1'b0; // [R20]
                end else if (~cpu_mask & pr_any) begin // [R16]
                    latched         <= 1'b1; // [R13]
                    int_take        <= 1'b1;
                    vec_sel         <= pr_vec; // [R17] [R24]
                    stack_pc_minus1 <= 1'b1; // [R20]
                end
            end
        end
    end

    // read mux; status flags mirror pending requests, writes ignored
    // loaded in the setup cycle so the access cycle can finish at once
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (bus_rd & ~penable) begin
            if (hit(paddr, `SRIC_OFS_RSTAT)) begin
                prdata <= {27'h0000000, reset_status};
            end else if (hit(paddr, `SRIC_OFS_INTSTAT)) begin
                prdata <= {16'h0000, int_req}; // [R22]
            end else if (hit(paddr, `SRIC_OFS_INTEN)) begin
                prdata <= {16'h0000, int_enable};
            end else if (hit(paddr, `SRIC_OFS_CONFIG)) begin
                prdata <= {30'h00000000, config_bits};
            end else if (hit(paddr, `SRIC_OFS_CTRL)) begin
                prdata <= {29'h00000000, latched, stop_active,
                           cpu_reset};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule // sric_top

// ==== sim/sric_cpu_model.sv ====
// Purpose: cpu core stand-in that completes each vector fetch
// Assumes: int_take is a one-cycle pulse from the block
// Notes:   fetch latency is a parameter so a held latch can be seen
`timescale 1ns/1ns
module sric_cpu_model #(
    parameter int FETCH_LAT = 6
) (
    input  wire  ref_clk,
    input  wire  rst,
    input  wire  int_take,
    output logic vec_fetch_done
);
    int cnt = 0;
    initial vec_fetch_done = 1'b0;
    // fetch ends some cycles after the take; a slow fetch keeps the
    // latch busy long enough for rival requests to arrive
    always @(posedge ref_clk) begin
        if (rst || int_take)
            cnt <= rst ? 0 : FETCH_LAT;
        else if (cnt > 0)
            cnt <= cnt - 1;
        vec_fetch_done <= !rst && cnt == 1;
    end
endmodule // sric_cpu_model

// ==== sim/sric_top_sva.sv ====
// Purpose: port checks of reset sequencing and interrupt latching
// Assumes: one clock, synchronous active-high rst
// Notes:   phase counts allow one crystal pulse of skew at phase edges
`timescale 1ns/1ns
module sric_top_sva (
    input wire       ref_clk,
    input wire       rst,
    input wire       xclk_fall,
    input wire       monitor_mode,
    input wire       reset_pin_vtst,
    input wire       irq_pin_vtst,
    input wire       low_voltage_reset,
    input wire       monitor_entry_reset,
    input wire       illegal_opcode,
    input wire       bus_access,
    input wire       opcode_fetch,
    input wire       addr_unmapped,
    input wire       instr_done,
    input wire       cpu_mask,
    input wire       swi_exec,
    input wire       vec_fetch_done,
    input wire       watchdog_disable,
    input wire       watchdog_tick,
    input wire       reset_pin_oe,
    input wire       cpu_reset,
    input wire       clocks_enable,
    input wire       int_take,
    input wire [4:0] vec_sel,
    input wire       stack_pc_minus1
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg  [12:0] pin_cnt;
    reg  [12:0] tail_cnt;
    reg  [13:0] gap_cnt;
    reg         lvr_seq;
    reg         gap_ok;
    reg         latched;
    wire        idle = !reset_pin_oe && !cpu_reset;
    wire        tick = xclk_fall && watchdog_tick;
    // crystal pulses per reset phase; the tick gap is trusted only over
    // a stretch free of reset and stop, since stop and internal resets clear the prescaler
    always @(posedge ref_clk) begin
        if (rst || idle) begin
            pin_cnt  <= 13'h0;
            tail_cnt <= 13'h0;
            lvr_seq  <= !rst && low_voltage_reset;
        end else if (xclk_fall) begin
            pin_cnt  <= pin_cnt + {12'h0, reset_pin_oe};
            tail_cnt <= tail_cnt + {12'h0, !reset_pin_oe};
        end
        gap_ok  <= !rst && idle && clocks_enable && (gap_ok || tick);
        gap_cnt <= (rst || tick) ? 14'h0 : gap_cnt + {13'h0, xclk_fall};
        latched <= !rst && (int_take || (latched && !vec_fetch_done));
    end
    AST_WDOG_OFF: assert property (
        watchdog_disable == (monitor_mode &&
                             (reset_pin_vtst || irq_pin_vtst)))
        else $error("watchdog gate wrong");
    AST_ILLEGAL_OPCODE_FLAG_RST: assert property (
        illegal_opcode && idle |=> reset_pin_oe && cpu_reset)
        else $error("illegal opcode gave no reset");
    AST_ADDR_RST: assert property (
        bus_access && opcode_fetch && addr_unmapped && idle |=> reset_pin_oe)
        else $error("unmapped fetch gave no reset");
    AST_MOD_RST: assert property (
        monitor_entry_reset && idle |=> reset_pin_oe)
        else $error("monitor entry gave no reset");
    AST_PIN_LEN: assert property (
        $fell(reset_pin_oe) |-> lvr_seq ? pin_cnt inside {[4095:4096]}
                                        : pin_cnt inside {[31:32]})
        else $error("pin phase length wrong");
    // a pin reset has no driven phase; its length is the pin's own
    AST_TAIL_LEN: assert property (
        $fell(cpu_reset) && pin_cnt != 13'h0 |-> tail_cnt inside {[63:64]})
        else $error("cpu release tail wrong");
    AST_TICK_GAP: assert property (
        watchdog_tick |-> xclk_fall && (!gap_ok || gap_cnt == 14'd8191))
        else $error("watchdog tick spacing wrong");
    AST_SWI_TAKE: assert property (
        swi_exec && instr_done && idle && !latched && !int_take
        |=> int_take && vec_sel == 5'h01 && !stack_pc_minus1)
        else $error("software interrupt not taken");
    AST_MASKED: assert property (
        instr_done && cpu_mask && !swi_exec |=> !int_take)
        else $error("masked request taken");
    AST_VEC_HOLD: assert property (
        !int_take && !cpu_reset && !$past(cpu_reset) |-> $stable(vec_sel))
        else $error("vector select moved without a take");
endmodule // sric_top_sva

// ==== sim/sric_top_test.sv ====
// Purpose: directed test of reset sources, stop recovery and interrupts
// Assumes: crystal falling-edge enable on every second clock
// Notes:   phase counts accept one pulse of skew
`timescale 1ns/1ns
`include "sric_consts.vh"
module sric_top_test;
    logic        ref_clk = 1'b0, rst = 1'b1, cpu_mask = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, q;
    logic        xclk_fall = 1'b0, ext_n = 1'b1;
    logic [2:0]  mon = 3'h0, bus = 3'h0;
    logic [6:0]  ev = 7'h0;
    logic [15:0] int_req = 16'h0;
    wire         monitor_mode, reset_pin_vtst, irq_pin_vtst, bus_access;
    wire         opcode_fetch, addr_unmapped, low_voltage_reset, stop_wake;
    wire         monitor_entry_reset, swi_exec, instr_done, stop_exec;
    wire         illegal_opcode, pready, pslverr, vec_fetch_done;
    wire         watchdog_disable, watchdog_tick, reset_pin_out, int_take;
    wire         reset_pin_oe, cpu_reset, stop_active, clocks_enable;
    wire         stack_pc_minus1, stack_high_index;
    wire [31:0]  prdata;
    wire [4:0]   vec_sel;
    int          err_total = 0, total_checks = 0, n, k;
    assign {monitor_mode, reset_pin_vtst, irq_pin_vtst} = mon;
    assign {bus_access, opcode_fetch, addr_unmapped} = bus;
    assign {low_voltage_reset, monitor_entry_reset, stop_wake, swi_exec,
            instr_done, stop_exec, illegal_opcode} = ev;
    // reset pin has a pull-up; the block pulls it low while enabled
    sric_top dut (.*, .reset_pin_in_n(ext_n && !reset_pin_oe));
    sric_cpu_model #(.FETCH_LAT(6)) cpu (.*);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) xclk_fall <= ~xclk_fall;
    task automatic apb(input logic wr, input logic [31:0] a, d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[FAIL] %0t count %0d", $time, got);
        end
    endtask
    // one-cycle cpu event pulse; back-to-back calls leave an idle edge
    task automatic fire(input logic [6:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 7'h0;
    endtask
    task automatic wait_idle;
        @(posedge ref_clk);
        while (cpu_reset !== 1'b0 || reset_pin_oe !== 1'b0 ||
               clocks_enable !== 1'b1)
            @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        $display("[FAIL] %0t timeout", $time);
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (k = 0; k < 9; k++)
            @(posedge ref_clk) mon <= k[2:0];
        apb(1'b0, 32'h0000_0020, 32'h0);
        chk(q | {31'h0, pslverr}, 32'h0);
        // opcode, stop as opcode, unmapped fetch, data read, monitor entry
        for (k = 0; k < 5; k++) begin
            apb(1'b1, `SRIC_OFS_RSTAT, 32'h1f);
            apb(1'b1, `SRIC_OFS_CONFIG, {31'h0, k != 1});
            bus <= (k == 2 || k == 3) ? {2'b10 | (k == 2), 1'b1} : 3'h0;
            fire(k == 0 ? 7'h01 : k == 1 ? 7'h02 : k == 4 ? 7'h20 : 7'h00);
            bus <= 3'h0;
            repeat (2) @(posedge ref_clk);
            q = {30'h0, reset_pin_oe, reset_pin_out};
            chk(q, {30'h0, k != 3, k == 3});
            wait_idle;
            apb(1'b0, `SRIC_OFS_RSTAT, 32'h0);
            n = k == 2 ? 2 : k == 3 ? 0 : k == 4 ? 8 : 1;
            chk(q & 32'hf, n);
        end
        apb(1'b1, `SRIC_OFS_RSTAT, 32'h1f);
        fire(7'h40);
        wait_idle;
        apb(1'b0, `SRIC_OFS_RSTAT, 32'h0);
        chk(q & 32'hf, 32'h4);
        apb(1'b1, `SRIC_OFS_INTEN, 32'hffff);
        // each flag against the lowest one, then a rival while latched
        for (k = 0; k < 16; k++) begin
            int_req <= 16'h8000 | (16'h1 << k);
            apb(1'b0, `SRIC_OFS_INTSTAT, 32'h0);
            chk(q, {16'h0, 16'h8000 | (16'h1 << k)});
            fire(7'h04);
            @(negedge ref_clk);
            q = {25'h0, int_take, stack_pc_minus1, vec_sel};
            chk(q, 32'h60 | (k + 2));
            @(posedge ref_clk) int_req <= 16'h0001;
            fire(7'h04);
            @(negedge ref_clk);
            chk({26'h0, int_take, vec_sel}, k + 2);
            repeat (8) @(posedge ref_clk);
        end
        {cpu_mask, int_req} <= {1'b1, 16'h0001};
        fire(7'h04);
        @(negedge ref_clk);
        chk({31'h0, int_take}, 32'h0);
        fire(7'h0c);
        @(negedge ref_clk);
        q = {25'h0, int_take, stack_pc_minus1, vec_sel};
        chk(q, 32'h41);
        repeat (8) @(posedge ref_clk);
        cpu_mask <= 1'b0;
        apb(1'b1, `SRIC_OFS_INTEN, 32'h0);
        fire(7'h04);
        @(negedge ref_clk);
        chk({30'h0, stack_high_index, int_take}, 32'h0);
        @(posedge ref_clk) int_req <= 16'h0;
        apb(1'b1, `SRIC_OFS_INTSTAT, 32'hffff_ffff);
        apb(1'b0, `SRIC_OFS_INTSTAT, 32'h0);
        chk(q, 32'h0);
        // stop recovery, short option first
        for (k = 0; k < 2; k++) begin
            apb(1'b1, `SRIC_OFS_CONFIG, {30'h0, k == 0, 1'b1});
            fire(7'h02);
            @(negedge ref_clk);
            chk({30'h0, stop_active, clocks_enable}, 32'h2);
            apb(1'b0, `SRIC_OFS_CTRL, 32'h0);
            chk(q, 32'h2);
            fire(7'h10);
            n = 0;
            while (clocks_enable !== 1'b1)
                @(posedge ref_clk) n += xclk_fall;
            chkn(n, k ? 4095 : 31, k ? 4097 : 33);
        end
        // pin reset, then two watchdog ticks on a running prescaler
        @(posedge ref_clk) ext_n <= 1'b0;
        repeat (150) @(posedge ref_clk);
        ext_n <= 1'b1;
        wait_idle;
        while (watchdog_tick !== 1'b1)
            @(posedge ref_clk);
        n = 0;
        do
            @(posedge ref_clk) n += xclk_fall;
        while (watchdog_tick !== 1'b1);
        chkn(n, 8192, 8192);
        end_of_test;
    end
endmodule // sric_top_test
bind sric_top sric_top_sva chk (.*);
